/* File: shared/branch_unit_pkg.sv */
package branch_unit_pkg;

    // register byte offsets on the avalon slave
    localparam logic [3:0] OFS_INSTR = 4'h0;
    localparam logic [3:0] OFS_PC = 4'h4;
    localparam logic [3:0] OFS_FLAGS = 4'h8;
    localparam logic [3:0] OFS_STATUS = 4'hc;

    // flags register bit positions
    localparam int FLG_CARRY = 0;
    localparam int FLG_ZERO = 2;
    localparam int FLG_OVERFLOW = 3;
    localparam int FLG_NEGATIVE = 4;

    // status register bit positions
    localparam int ST_BUSY = 0;
    localparam int ST_DONE = 1;
    localparam int ST_TAKEN = 2;
    localparam int ST_UNKNOWN = 3;
    localparam int ST_CYC_LO = 4;

    // reset values
    localparam logic [15:0] INSTR_RST = 16'h0000;
    localparam logic [4:0] FLAGS_RST = 5'h00;

    // opcode encodings
    localparam logic [7:0] OPC_ON_NEGATIVE = 8'he6;
    localparam logic [7:0] OPC_ON_NO_CARRY = 8'he3;
    localparam logic [7:0] OPC_ON_NON_NEGATIVE = 8'he7;
    localparam logic [7:0] OPC_ON_NO_OVERFLOW = 8'he5;
    localparam logic [7:0] OPC_ON_NONZERO = 8'he1;
    localparam logic [4:0] OPC_ALWAYS = 5'h1a;

    // timing: quarter phases per instruction cycle, bytes per program word
    localparam logic [1:0] LAST_PHASE = 2'h3;
    localparam int WORD_BYTES = 2;
    localparam logic [1:0] CYC_UNTAKEN = 2'h1;
    localparam logic [1:0] CYC_TAKEN = 2'h2;

    typedef enum logic [2:0] {
        KIND_NONE,
        KIND_ON_NEGATIVE,
        KIND_ON_NO_CARRY,
        KIND_ON_NON_NEGATIVE,
        KIND_ON_NO_OVERFLOW,
        KIND_ON_NONZERO,
        KIND_ALWAYS
    } kind_t;

    typedef struct packed {
        logic negative;
        logic overflow;
        logic zero;
        logic carry;
    } flags_t;

endpackage : branch_unit_pkg

/* File: design/relative_branch_exec_unit.sv */
// Overview of operation
// RULE1: taken branch loads pc with incremented pc plus twice the signed offset
// RULE2: untaken conditional branch takes one instruction cycle, taken takes two
// RULE3: q1 decode, q2 read offset, q3 process, q4 write pc if taken; then nop cycle
// RULE4: conditional offset is signed 8-bit, -128..127, doubled before the add
// RULE5: opcode e6 branches when negative is one
// RULE6: opcode e3 branches when carry is zero
// RULE7: opcode e7 branches when negative is zero
// RULE8: opcode e5 branches when overflow is zero
// RULE9: opcode e1 branches when zero is zero
// RULE10: prefix 11010 with 11-bit offset always branches, always two cycles
// RULE11: branch execution leaves all flags unchanged
// RULE12: each branch is one 16-bit word; fall-through is address plus 2
`timescale 1ns/1ps
`default_nettype none

module relative_branch_exec_unit #(
    parameter int PC_W = 21
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic flushing
);

    typedef enum logic [1:0] {S_IDLE, S_EXEC, S_FLUSH} state_t;

    state_t state_r;
    logic [1:0] phase_r;
    logic [15:0] instr_r;
    logic [PC_W-1:0] pc_r;
    logic [PC_W-1:0] startPc_r;
    logic [PC_W-1:0] offset_r;
    logic [PC_W-1:0] target_r;
    branch_unit_pkg::flags_t flags_r;
    branch_unit_pkg::kind_t kind_r;
    logic taken_r;
    logic done_r;
    logic unknown_r;
    logic [1:0] cycles_r;
    logic waitReq_r;
    logic [31:0] readData_r;
    logic flushing_r;

    logic accept;
    logic wrAck;
    logic start;
    logic busy;
    logic doneSet;
    logic lastPhase;

    function automatic branch_unit_pkg::kind_t decode(input logic [15:0] w);
        branch_unit_pkg::kind_t k;
        k = branch_unit_pkg::KIND_NONE;
        if (w[15:11] == branch_unit_pkg::OPC_ALWAYS) begin
            k = branch_unit_pkg::KIND_ALWAYS; // [RULE10]
        end else begin
            unique case (w[15:8])
                branch_unit_pkg::OPC_ON_NEGATIVE: k = branch_unit_pkg::KIND_ON_NEGATIVE; // [RULE5]
                branch_unit_pkg::OPC_ON_NO_CARRY: k = branch_unit_pkg::KIND_ON_NO_CARRY; // [RULE6]
                branch_unit_pkg::OPC_ON_NON_NEGATIVE: k = branch_unit_pkg::KIND_ON_NON_NEGATIVE; // [RULE7]
                branch_unit_pkg::OPC_ON_NO_OVERFLOW: k = branch_unit_pkg::KIND_ON_NO_OVERFLOW; // [RULE8]
                branch_unit_pkg::OPC_ON_NONZERO: k = branch_unit_pkg::KIND_ON_NONZERO; // [RULE9]
                default: k = branch_unit_pkg::KIND_NONE;
            endcase
        end
        return k;
    endfunction : decode

    function automatic logic condition(input branch_unit_pkg::kind_t k,
                                       input branch_unit_pkg::flags_t f);
        logic c;
        c = 1'b0;
        unique case (k)
            branch_unit_pkg::KIND_ON_NEGATIVE: c = f.negative; // [RULE5]
            branch_unit_pkg::KIND_ON_NO_CARRY: c = !f.carry; // [RULE6]
            branch_unit_pkg::KIND_ON_NON_NEGATIVE: c = !f.negative; // [RULE7]
            branch_unit_pkg::KIND_ON_NO_OVERFLOW: c = !f.overflow; // [RULE8]
            branch_unit_pkg::KIND_ON_NONZERO: c = !f.zero; // [RULE9]
            branch_unit_pkg::KIND_ALWAYS: c = 1'b1; // [RULE10]
            branch_unit_pkg::KIND_NONE: c = 1'b0;
        endcase
        return c;
    endfunction : condition

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] be);
        logic [31:0] m;
        m = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                m[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return m;
    endfunction : merge

    // one wait cycle per access: the answer comes from a flip-flop
    assign accept = ce && (avs_read || avs_write) && waitReq_r;
    assign wrAck = ce && avs_write && !waitReq_r;
    assign busy = (state_r != S_IDLE);
    assign start = wrAck && !busy && (avs_address == branch_unit_pkg::OFS_INSTR);
    assign lastPhase = (phase_r == branch_unit_pkg::LAST_PHASE);
    assign doneSet = ce && lastPhase &&
                     ((state_r == S_FLUSH) || (state_r == S_EXEC && !taken_r));

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            waitReq_r <= 1'b1;
        end else if (accept) begin
            waitReq_r <= 1'b0;
        end else if (ce) begin
            waitReq_r <= 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            readData_r <= 32'h0000_0000;
        end else if (accept) begin
            unique case (avs_address)
                branch_unit_pkg::OFS_INSTR: readData_r <= {16'h0000, instr_r};
                branch_unit_pkg::OFS_PC: readData_r <= 32'(pc_r);
                branch_unit_pkg::OFS_FLAGS: begin
                    readData_r <= 32'h0000_0000;
                    readData_r[branch_unit_pkg::FLG_CARRY] <= flags_r.carry;
                    readData_r[branch_unit_pkg::FLG_ZERO] <= flags_r.zero;
                    readData_r[branch_unit_pkg::FLG_OVERFLOW] <= flags_r.overflow;
                    readData_r[branch_unit_pkg::FLG_NEGATIVE] <= flags_r.negative;
                end
                branch_unit_pkg::OFS_STATUS: begin
                    readData_r <= 32'h0000_0000;
                    readData_r[branch_unit_pkg::ST_BUSY] <= busy;
                    readData_r[branch_unit_pkg::ST_DONE] <= done_r;
                    readData_r[branch_unit_pkg::ST_TAKEN] <= taken_r;
                    readData_r[branch_unit_pkg::ST_UNKNOWN] <= unknown_r;
                    readData_r[branch_unit_pkg::ST_CYC_LO +: 2] <= cycles_r;
                end
                default: readData_r <= 32'h0000_0000;
            endcase
        end
    end

    // instruction register; a write while busy is dropped so the running word stays intact
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            instr_r <= branch_unit_pkg::INSTR_RST;
        end else if (start) begin
            instr_r <= 16'(merge({16'h0000, instr_r}, avs_writedata, avs_byteenable));
        end
    end

    // flags are software state only; execution never writes them
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            flags_r <= '0;
        end else if (wrAck && !busy && avs_address == branch_unit_pkg::OFS_FLAGS
                     && avs_byteenable[0]) begin // [RULE11]
            flags_r.carry <= avs_writedata[branch_unit_pkg::FLG_CARRY];
            flags_r.zero <= avs_writedata[branch_unit_pkg::FLG_ZERO];
            flags_r.overflow <= avs_writedata[branch_unit_pkg::FLG_OVERFLOW];
            flags_r.negative <= avs_writedata[branch_unit_pkg::FLG_NEGATIVE];
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_r <= S_IDLE;
            phase_r <= 2'h0;
        end else if (ce) begin
            unique case (state_r)
                S_IDLE: begin
                    phase_r <= 2'h0;
                    if (start) begin
                        state_r <= S_EXEC;
                    end
                end
                S_EXEC: begin
                    phase_r <= phase_r + 2'h1;
                    if (lastPhase) begin
                        state_r <= taken_r ? S_FLUSH : S_IDLE; // [RULE2]
                    end
                end
                S_FLUSH: begin
                    phase_r <= phase_r + 2'h1;
                    if (lastPhase) begin
                        state_r <= S_IDLE; // [RULE3]
                    end
                end
            endcase
        end
    end

    // q1 decode, q2 offset literal, q3 target and condition
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            kind_r <= branch_unit_pkg::KIND_NONE;
            offset_r <= '0;
            target_r <= '0;
            taken_r <= 1'b0;
        end else if (ce && state_r == S_EXEC) begin
            unique case (phase_r)
                2'h0: begin
                    kind_r <= decode(instr_r); // [RULE3]
                    taken_r <= 1'b0;
                end
                2'h1: begin
                    if (kind_r == branch_unit_pkg::KIND_ALWAYS) begin
                        offset_r <= PC_W'(signed'(instr_r[10:0])); // [RULE10]
                    end else begin
                        offset_r <= PC_W'(signed'(instr_r[7:0])); // [RULE4]
                    end
                end
                2'h2: begin
                    target_r <= pc_r + PC_W'({offset_r, 1'b0}); // [RULE1]
                    taken_r <= condition(kind_r, flags_r);
                end
                2'h3: begin
                    taken_r <= taken_r;
                end
            endcase
        end
    end

    // program counter: fetch increment in q1, target load in q4 only when taken
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pc_r <= '0;
            startPc_r <= '0;
        end else if (ce) begin
            if (wrAck && !busy && avs_address == branch_unit_pkg::OFS_PC) begin
                pc_r <= PC_W'(merge(32'(pc_r), avs_writedata, avs_byteenable));
            end else if (state_r == S_EXEC && phase_r == 2'h0) begin
                startPc_r <= pc_r;
                pc_r <= pc_r + PC_W'(branch_unit_pkg::WORD_BYTES); // [RULE12]
            end else if (state_r == S_EXEC && lastPhase && taken_r) begin
                pc_r <= target_r; // [RULE1]
            end
        end
    end

    // done is sticky; a completion in the same cycle as its clear wins
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            done_r <= 1'b0;
            unknown_r <= 1'b0;
            cycles_r <= 2'h0;
        end else if (ce) begin
            if (doneSet) begin
                done_r <= 1'b1;
                unknown_r <= (kind_r == branch_unit_pkg::KIND_NONE);
                cycles_r <= taken_r ? branch_unit_pkg::CYC_TAKEN
                                    : branch_unit_pkg::CYC_UNTAKEN; // [RULE2]
            end else if (wrAck && avs_address == branch_unit_pkg::OFS_STATUS
                         && avs_writedata[branch_unit_pkg::ST_DONE]) begin
                done_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            flushing_r <= 1'b0;
        end else if (ce) begin
            flushing_r <= (state_r == S_EXEC && lastPhase && taken_r) ||
                          (state_r == S_FLUSH && !lastPhase); // [RULE3]
        end
    end

    assign avs_waitrequest = waitReq_r;
    assign avs_readdata = readData_r;
    assign flushing = flushing_r;

    property p_target;
        @(posedge clk) disable iff (!rst_n)
        (ce && state_r == S_EXEC && lastPhase && taken_r) |=>
            (pc_r == $past(startPc_r) + PC_W'(2) + PC_W'({$past(offset_r), 1'b0}));
    endproperty
    a_target: assert property (p_target) else $error("taken pc is not pc+2+2n"); // [RULE1]

    property p_cycles;
        @(posedge clk) disable iff (!rst_n)
        (ce && doneSet) |=> (cycles_r == ($past(taken_r) ? 2'h2 : 2'h1));
    endproperty
    a_cycles: assert property (p_cycles) else $error("cycle count mismatch"); // [RULE2]

    property p_flush_nop;
        @(posedge clk) disable iff (!rst_n)
        (state_r == S_FLUSH) |=> ($stable(pc_r) && $stable(flags_r));
    endproperty
    a_flush_nop: assert property (p_flush_nop) else $error("flush cycle changed state"); // [RULE3]

    property p_offset_range;
        @(posedge clk) disable iff (!rst_n)
        (state_r == S_EXEC && phase_r == 2'h2 && kind_r != branch_unit_pkg::KIND_ALWAYS) |->
            ($signed(offset_r) >= -128 && $signed(offset_r) <= 127);
    endproperty
    a_offset_range: assert property (p_offset_range) else $error("offset out of range"); // [RULE4]

    property p_neg;
        @(posedge clk) disable iff (!rst_n)
        (state_r == S_EXEC && lastPhase && kind_r == branch_unit_pkg::KIND_ON_NEGATIVE) |->
            (taken_r == flags_r.negative);
    endproperty
    a_neg: assert property (p_neg) else $error("negative branch wrong"); // [RULE5]

    property p_nocarry;
        @(posedge clk) disable iff (!rst_n)
        (state_r == S_EXEC && lastPhase && kind_r == branch_unit_pkg::KIND_ON_NO_CARRY) |->
            (taken_r == !flags_r.carry);
    endproperty
    a_nocarry: assert property (p_nocarry) else $error("no-carry branch wrong"); // [RULE6]

    property p_nonneg;
        @(posedge clk) disable iff (!rst_n)
        (state_r == S_EXEC && lastPhase && kind_r == branch_unit_pkg::KIND_ON_NON_NEGATIVE) |->
            (taken_r == !flags_r.negative);
    endproperty
    a_nonneg: assert property (p_nonneg) else $error("non-negative branch wrong"); // [RULE7]

    property p_noov;
        @(posedge clk) disable iff (!rst_n)
        (state_r == S_EXEC && lastPhase && kind_r == branch_unit_pkg::KIND_ON_NO_OVERFLOW) |->
            (taken_r == !flags_r.overflow);
    endproperty
    a_noov: assert property (p_noov) else $error("no-overflow branch wrong"); // [RULE8]

    property p_nz;
        @(posedge clk) disable iff (!rst_n)
        (state_r == S_EXEC && lastPhase && kind_r == branch_unit_pkg::KIND_ON_NONZERO) |->
            (taken_r == !flags_r.zero);
    endproperty
    a_nz: assert property (p_nz) else $error("nonzero branch wrong"); // [RULE9]

    property p_always;
        @(posedge clk) disable iff (!rst_n)
        (ce && state_r == S_EXEC && lastPhase && kind_r == branch_unit_pkg::KIND_ALWAYS) |=>
            (state_r == S_FLUSH);
    endproperty
    a_always: assert property (p_always) else $error("always branch not taken"); // [RULE10]

    property p_flags_kept;
        @(posedge clk) disable iff (!rst_n)
        busy |=> $stable(flags_r);
    endproperty
    a_flags_kept: assert property (p_flags_kept) else $error("flags changed by branch"); // [RULE11]

    property p_fallthrough;
        @(posedge clk) disable iff (!rst_n)
        (ce && state_r == S_EXEC && lastPhase && !taken_r) |=>
            (pc_r == $past(startPc_r) + PC_W'(2));
    endproperty
    a_fallthrough: assert property (p_fallthrough) else $error("fall-through pc wrong"); // [RULE12]

    c_taken: cover property (@(posedge clk) disable iff (!rst_n)
        (state_r == S_EXEC && lastPhase && taken_r) ##1 (state_r == S_FLUSH));
    c_untaken: cover property (@(posedge clk) disable iff (!rst_n)
        (state_r == S_EXEC && lastPhase && !taken_r && kind_r != branch_unit_pkg::KIND_NONE));
    c_always: cover property (@(posedge clk) disable iff (!rst_n)
        (kind_r == branch_unit_pkg::KIND_ALWAYS && state_r == S_FLUSH));
    c_backward: cover property (@(posedge clk) disable iff (!rst_n)
        (state_r == S_EXEC && phase_r == 2'h3 && taken_r && offset_r[PC_W-1]));

endmodule : relative_branch_exec_unit

`default_nettype wire

/* File: dv/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    localparam logic [4:0] FC = 5'h01 << branch_unit_pkg::FLG_CARRY;
    localparam logic [4:0] FZ = 5'h01 << branch_unit_pkg::FLG_ZERO;
    localparam logic [4:0] FV = 5'h01 << branch_unit_pkg::FLG_OVERFLOW;
    localparam logic [4:0] FN = 5'h01 << branch_unit_pkg::FLG_NEGATIVE;

    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic ce = 1'b1;
    logic [3:0] avsAddress = 4'h0;
    logic avsRead = 1'b0;
    logic avsWrite = 1'b0;
    logic [31:0] avsWritedata = 32'h0;
    logic [3:0] avsByteenable = 4'hf;
    logic [31:0] avsReaddata;
    logic avsWaitrequest;
    logic flushing;
    int n_fail = 0;
    int samples_checked = 0;
    int flushCnt = 0;
    int cycleCnt = 0;

    relative_branch_exec_unit u_dut (
        .clk(clk),
        .rst_n(rst_n),
        .ce(ce),
        .avs_address(avsAddress),
        .avs_read(avsRead),
        .avs_write(avsWrite),
        .avs_writedata(avsWritedata),
        .avs_byteenable(avsByteenable),
        .avs_readdata(avsReaddata),
        .avs_waitrequest(avsWaitrequest),
        .flushing(flushing)
    );

    always #5 clk = ~clk;

    // the flush cycle length is judged from this tally, cleared before each run whose flush length is checked (busy_drop never clears it)
    always @(posedge clk) begin
        if (flushing === 1'b1) flushCnt++;
    end

    // a hung handshake would otherwise stall the run forever
    always @(posedge clk) begin
        cycleCnt++;
        if (cycleCnt == 5000) begin
            n_fail++;
            print_verdict();
        end
    end

    task automatic print_verdict();
        if (n_fail == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : print_verdict

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            $display("unexpected %s expected %h seen %h", what, exp, got);
            n_fail++;
        end
    endtask : check

    task automatic bus_write(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        avsAddress <= a;
        avsWritedata <= d;
        avsWrite <= 1'b1;
        do @(posedge clk); while (avsWaitrequest !== 1'b0);
        avsWrite <= 1'b0;
    endtask : bus_write

    task automatic bus_read(input logic [3:0] a, output logic [31:0] d);
        @(posedge clk);
        avsAddress <= a;
        avsRead <= 1'b1;
        do @(posedge clk); while (avsWaitrequest !== 1'b0);
        d = avsReaddata;
        avsRead <= 1'b0;
    endtask : bus_read

    task automatic wait_done(output logic [31:0] d);
        int n;
        n = 0;
        do begin
            bus_read(branch_unit_pkg::OFS_STATUS, d);
            n++;
        end while (d[branch_unit_pkg::ST_DONE] !== 1'b1 && n < 20);
    endtask : wait_done

    task automatic reset_values();
        logic [31:0] d;
        bus_read(branch_unit_pkg::OFS_INSTR, d);
        check("instr after reset", 32'h0, d);
        bus_read(branch_unit_pkg::OFS_PC, d);
        check("pc after reset", 32'h0, d);
        bus_read(branch_unit_pkg::OFS_FLAGS, d);
        check("flags after reset", 32'h0, d);
        bus_read(branch_unit_pkg::OFS_STATUS, d);
        check("status after reset", 32'h0, d);
        bus_write(4'h2, 32'hffffffff);
        bus_read(4'h2, d);
        check("unmapped read", 32'h0, d);
        bus_write(branch_unit_pkg::OFS_PC, 32'h0012_3456);
        avsByteenable <= 4'h1;
        bus_write(branch_unit_pkg::OFS_PC, 32'h0000_00ab);
        avsByteenable <= 4'hf;
        bus_read(branch_unit_pkg::OFS_PC, d);
        check("pc after lane-0 write", 32'h0012_34ab, d);
    endtask : reset_values

    // expectations come from the opcode table, flags and the doubled signed offset
    task automatic run_case(input logic [15:0] ins, input logic [4:0] fl, input logic [20:0] pc0);
        logic tk;
        logic unk;
        logic [20:0] off;
        logic [20:0] pcExp;
        logic [1:0] cyc;
        logic [31:0] d;
        tk = 1'b0;
        unk = 1'b0;
        off = {{13{ins[7]}}, ins[7:0]};
        if (ins[15:11] == branch_unit_pkg::OPC_ALWAYS) begin
            tk = 1'b1;
            off = {{10{ins[10]}}, ins[10:0]};
        end else begin
            case (ins[15:8])
                branch_unit_pkg::OPC_ON_NEGATIVE: tk = (fl & FN) != 5'h00;
                branch_unit_pkg::OPC_ON_NO_CARRY: tk = (fl & FC) == 5'h00;
                branch_unit_pkg::OPC_ON_NON_NEGATIVE: tk = (fl & FN) == 5'h00;
                branch_unit_pkg::OPC_ON_NO_OVERFLOW: tk = (fl & FV) == 5'h00;
                branch_unit_pkg::OPC_ON_NONZERO: tk = (fl & FZ) == 5'h00;
                default: unk = 1'b1;
            endcase
        end
        pcExp = tk ? pc0 + 21'h2 + (off << 1) : pc0 + 21'h2;
        cyc = tk ? branch_unit_pkg::CYC_TAKEN : branch_unit_pkg::CYC_UNTAKEN;
        bus_write(branch_unit_pkg::OFS_STATUS, 32'h2);
        bus_write(branch_unit_pkg::OFS_FLAGS, {27'h0, fl});
        bus_write(branch_unit_pkg::OFS_PC, {11'h0, pc0});
        flushCnt = 0;
        bus_write(branch_unit_pkg::OFS_INSTR, {16'h0, ins});
        wait_done(d);
        check("status", {26'h0, cyc, unk, tk, 2'b10}, d);
        bus_read(branch_unit_pkg::OFS_PC, d);
        check("pc", {11'h0, pcExp}, d);
        bus_read(branch_unit_pkg::OFS_FLAGS, d);
        check("flags", {27'h0, fl}, d);
        check("flush cycles", tk ? 32'h4 : 32'h0, flushCnt);
    endtask : run_case

    // writes landing while a taken branch runs must all be dropped
    task automatic busy_drop();
        logic [31:0] d;
        bus_write(branch_unit_pkg::OFS_STATUS, 32'h2);
        bus_write(branch_unit_pkg::OFS_FLAGS, 32'h0);
        bus_write(branch_unit_pkg::OFS_PC, 32'h200);
        bus_write(branch_unit_pkg::OFS_INSTR, 32'he105);
        bus_write(branch_unit_pkg::OFS_INSTR, 32'hd000);
        bus_write(branch_unit_pkg::OFS_FLAGS, 32'h1f);
        wait_done(d);
        bus_read(branch_unit_pkg::OFS_INSTR, d);
        check("instr after busy writes", 32'he105, d);
        bus_read(branch_unit_pkg::OFS_FLAGS, d);
        check("flags after busy writes", 32'h0, d);
        // only two back-to-back writes land inside one taken run, so pc gets a run of its own
        bus_write(branch_unit_pkg::OFS_STATUS, 32'h2);
        bus_write(branch_unit_pkg::OFS_INSTR, 32'he105);
        bus_write(branch_unit_pkg::OFS_PC, 32'h7);
        wait_done(d);
        bus_read(branch_unit_pkg::OFS_PC, d);
        check("pc after busy writes", 32'h218, d);
    endtask : busy_drop

    // a low enable mid-run must hold the branch where it stands, flush length included
    task automatic ce_freeze();
        logic [31:0] d;
        bus_write(branch_unit_pkg::OFS_STATUS, 32'h2);
        bus_write(branch_unit_pkg::OFS_FLAGS, 32'h0);
        bus_write(branch_unit_pkg::OFS_PC, 32'h10);
        flushCnt = 0;
        bus_write(branch_unit_pkg::OFS_INSTR, 32'he102);
        ce <= 1'b0;
        repeat (10) @(posedge clk);
        check("flush cycles while frozen", 32'h0, flushCnt);
        ce <= 1'b1;
        wait_done(d);
        check("status after freeze", 32'h26, d);
        bus_read(branch_unit_pkg::OFS_PC, d);
        check("pc after freeze", 32'h16, d);
        check("flush cycles after freeze", 32'h4, flushCnt);
    endtask : ce_freeze

    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        reset_values();
        run_case(16'he67f, FN, 21'h100);
        run_case(16'he67f, FC | FZ | FV, 21'h100);
        run_case(16'he380, 5'h00, 21'h400);
        run_case(16'he380, FC, 21'h400);
        run_case(16'he705, FC | FZ | FV, 21'h40);
        run_case(16'he705, FN, 21'h40);
        run_case(16'he5fe, FN | FC | FZ, 21'h80);
        run_case(16'he5fe, FV, 21'h80);
        run_case(16'he101, FN | FC | FV, 21'h1ffffe);
        run_case(16'he101, FZ, 21'h1ffffe);
        run_case(16'hd3ff, FN | FC | FZ | FV, 21'h1000);
        run_case(16'hd400, FN | FC | FZ | FV, 21'h1000);
        run_case(16'hd000, 5'h00, 21'h20);
        run_case(16'hffff, 5'h00, 21'h30);
        busy_drop();
        ce_freeze();
        print_verdict();
    end
endmodule : tb_top

`default_nettype wire
